// ==== fieldbus_process_data_mapper.sv ====
// What this block does
// (RQ1) Copy transmit inputs into the 8-byte object and hand it to the module.
// (RQ2) Bytes 1-2 carry the status word, some bits set by configuration.
// (RQ3) Selector 34 at 0 puts analog word 1 on bytes 3-4.
// (RQ4) Selector 34 at 3 puts phase 2 low half on bytes 3-4.
// (RQ5) Selector 56 at 0 puts analog word 2 on bytes 5-6.
// (RQ6) Selector 56 at 1 puts digital bits 0-15 on bytes 5-6.
// (RQ7) Selector 56 at 2 puts phase 1 low half on bytes 5-6.
// (RQ8) Selector 56 at 3 puts phase 2 high half on bytes 5-6.
// (RQ9) Selector 78 at 0 puts analog word 3 on bytes 7-8.
// (RQ10) Selector 78 at 1 puts digital bits 16-31 on bytes 7-8.
// (RQ11) Selector 78 at 2 puts phase 1 high half on bytes 7-8.
// (RQ12) Analog 16384 is full scale; phase 65536 is one revolution.
// (RQ13) Received bytes 3-4 become analog receive word 1.
// (RQ14) Received bytes 5-8 read as analog words, digital bits or phase.
// (RQ15) Received bytes 1-2 form control word; bits 3,8-11 to device control.
// (RQ16) Undefined selector codes drive their byte pair to zero.
// (RQ17) All eight bytes change together once per processing cycle.
`timescale 1ns/100ps
`default_nettype none
module fieldbus_process_data_mapper
	import fieldbus_map_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [REG_ADDR_W-1:0] reg_addr,
	input wire logic [REG_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [REG_DATA_W-1:0] reg_rdata,
	// transmit sources
	input wire logic [15:0] status_word,
	input wire logic [15:0] analog_tx_word1,
	input wire logic [15:0] analog_tx_word2,
	input wire logic [15:0] analog_tx_word3,
	input wire logic [31:0] phase_tx_value1,
	input wire logic [31:0] phase_tx_value2,
	input wire logic [31:0] free_digital_output_set,
	// outgoing object to the module
	output logic [OBJ_W-1:0] process_data_object,
	output logic process_data_object_valid,
	// incoming object from the module
	input wire logic [OBJ_W-1:0] rx_object,
	input wire logic rx_object_valid,
	// received fields
	output logic [4:0] device_control_bits,
	output logic [10:0] control_free_bits,
	output logic [15:0] analog_rx_word1,
	output logic [15:0] analog_rx_word2,
	output logic [15:0] analog_rx_word3,
	output logic [31:0] rx_digital_bits,
	output logic [31:0] rx_phase_value,
	output logic rx_fields_valid
);
	typedef struct packed
	{
		logic [1:0] sel34;
		logic [1:0] sel56;
		logic [1:0] sel78;
		logic [15:0] stat_mask;
		logic [15:0] stat_value;
		logic [OBJ_W-1:0] tx_obj;
		logic tx_valid;
		logic [15:0] cycles;
		logic [REG_DATA_W-1:0] rdata;
	} map_state_t;

	map_state_t state_reg;
	map_state_t state_next;
	logic proc_tick;
	logic [15:0] pair12;
	logic [15:0] pair34;
	logic [15:0] pair56;
	logic [15:0] pair78;
	logic [REG_DATA_W-1:0] read_mux;

	rx_fields_if rx ();

	// processing cycle pacing
	proc_cycle_divider u_divider
	(
		.clk(clk),
		.rst(rst),
		.tick(proc_tick)
	);

	// receive-side capture and split
	rx_object_splitter u_splitter
	(
		.clk(clk),
		.rst(rst),
		.rx_object(rx_object),
		.rx_object_valid(rx_object_valid),
		.rx(rx)
	);

	// status word with configured bits overridden
	assign pair12 = (status_word & ~state_reg.stat_mask)
		| (state_reg.stat_value & state_reg.stat_mask); // RQ2

	// bytes 3-4; codes 1 and 2 have no meaning and send zero
	always_comb
	begin
		unique case (state_reg.sel34)
			SEL34_ANALOG: pair34 = analog_tx_word1; // RQ3 RQ12
			SEL34_PH2_LO: pair34 = phase_tx_value2[15:0]; // RQ4
			default: pair34 = 16'h0000; // RQ16
		endcase
	end

	// bytes 5-6; all four codes are in use
	always_comb
	begin
		unique case (state_reg.sel56)
			SEL56_ANALOG: pair56 = analog_tx_word2; // RQ5
			SEL56_DIG_LO: pair56 = free_digital_output_set[15:0]; // RQ6
			SEL56_PH1_LO: pair56 = phase_tx_value1[15:0]; // RQ7
			SEL56_PH2_HI: pair56 = phase_tx_value2[31:16]; // RQ8
		endcase
	end

	// bytes 7-8; code 3 has no meaning and sends zero
	always_comb
	begin
		unique case (state_reg.sel78)
			SEL78_ANALOG: pair78 = analog_tx_word3; // RQ9
			SEL78_DIG_HI: pair78 = free_digital_output_set[31:16]; // RQ10
			SEL78_PH1_HI: pair78 = phase_tx_value1[31:16]; // RQ11
			default: pair78 = 16'h0000; // RQ16
		endcase
	end

	// register readback; unmapped addresses read zero
	always_comb
	begin
		unique case (reg_addr)
			ADDR_SEL34: read_mux = {14'h0000, state_reg.sel34};
			ADDR_SEL56: read_mux = {14'h0000, state_reg.sel56};
			ADDR_SEL78: read_mux = {14'h0000, state_reg.sel78};
			ADDR_STAT_MASK: read_mux = state_reg.stat_mask;
			ADDR_STAT_VALUE: read_mux = state_reg.stat_value;
			ADDR_TX_PAIR12: read_mux = state_reg.tx_obj[PAIR12_LSB +: 16];
			ADDR_TX_PAIR34: read_mux = state_reg.tx_obj[PAIR34_LSB +: 16];
			ADDR_TX_PAIR56: read_mux = state_reg.tx_obj[PAIR56_LSB +: 16];
			ADDR_TX_PAIR78: read_mux = state_reg.tx_obj[PAIR78_LSB +: 16];
			ADDR_RX_CTRL: read_mux = rx.control_word;
			ADDR_CYCLES: read_mux = state_reg.cycles;
			default: read_mux = 16'h0000;
		endcase
	end

	// next state: register writes, object update, read answer
	always_comb
	begin
		state_next = state_reg;
		state_next.tx_valid = 1'b0;
		state_next.rdata = 16'h0000;
		if (reg_wr)
		begin
			unique case (reg_addr)
				ADDR_SEL34: state_next.sel34 = reg_wdata[1:0];
				ADDR_SEL56: state_next.sel56 = reg_wdata[1:0];
				ADDR_SEL78: state_next.sel78 = reg_wdata[1:0];
				ADDR_STAT_MASK: state_next.stat_mask = reg_wdata;
				ADDR_STAT_VALUE: state_next.stat_value = reg_wdata;
				default: ;
			endcase
		end
		// a selector written on the tick takes effect next cycle,
		// so one object never mixes old and new settings
		if (proc_tick)
		begin
			state_next.tx_obj = {pair78, pair56, pair34, pair12}; // RQ17
			state_next.tx_valid = 1'b1; // RQ1
			state_next.cycles = state_reg.cycles + 1'b1;
		end
		if (reg_rd)
			state_next.rdata = read_mux;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= '0;
			state_reg.sel34 <= SEL_RESET;
			state_reg.sel56 <= SEL_RESET;
			state_reg.sel78 <= SEL_RESET;
			state_reg.stat_mask <= STAT_MASK_RESET;
			state_reg.stat_value <= STAT_VALUE_RESET;
		end
		else
			state_reg <= state_next;
	end

	// outputs toward the module and software
	assign process_data_object = state_reg.tx_obj; // RQ1
	assign process_data_object_valid = state_reg.tx_valid;
	assign reg_rdata = state_reg.rdata;

	// received control word split by destination
	assign device_control_bits = {rx.control_word[CTRL_FIELD_MSB:
		CTRL_FIELD_LSB], rx.control_word[CTRL_BIT_SINGLE]}; // RQ15
	assign control_free_bits = {rx.control_word[15:12],
		rx.control_word[7:4], rx.control_word[2:0]}; // RQ15
	assign analog_rx_word1 = rx.analog1; // RQ13
	assign analog_rx_word2 = rx.analog2; // RQ14
	assign analog_rx_word3 = rx.analog3; // RQ14
	assign rx_digital_bits = rx.digital; // RQ14
	assign rx_phase_value = rx.phase; // RQ14
	assign rx_fields_valid = rx.valid;

	// ticks are exactly one processing cycle apart
	localparam int TICK_GAP = PROC_CYCLE_TICKS;

	// checks on the mapping
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_tx_valid_pulse: assert property ( // RQ1
		proc_tick |=> process_data_object_valid ##1
		!process_data_object_valid)
		else $error("object valid not a single pulse after tick");

	a_status_bytes: assert property ( // RQ2
		proc_tick |=> process_data_object[15:0] ==
		(($past(status_word) & ~$past(state_reg.stat_mask))
		| ($past(state_reg.stat_value) & $past(state_reg.stat_mask))))
		else $error("bytes 1-2 differ from status word");

	a_pair34_analog: assert property ( // RQ3
		proc_tick && state_reg.sel34 == SEL34_ANALOG |=>
		process_data_object[31:16] == $past(analog_tx_word1))
		else $error("bytes 3-4 not analog word 1");

	a_pair34_phase: assert property ( // RQ4
		proc_tick && state_reg.sel34 == SEL34_PH2_LO |=>
		process_data_object[31:16] == $past(phase_tx_value2[15:0]))
		else $error("bytes 3-4 not phase 2 low");

	a_pair56_analog: assert property ( // RQ5
		proc_tick && state_reg.sel56 == SEL56_ANALOG |=>
		process_data_object[47:32] == $past(analog_tx_word2))
		else $error("bytes 5-6 not analog word 2");

	a_pair56_digital: assert property ( // RQ6
		proc_tick && state_reg.sel56 == SEL56_DIG_LO |=>
		process_data_object[47:32] ==
		$past(free_digital_output_set[15:0]))
		else $error("bytes 5-6 not digital low");

	a_pair56_ph1: assert property ( // RQ7
		proc_tick && state_reg.sel56 == SEL56_PH1_LO |=>
		process_data_object[47:32] == $past(phase_tx_value1[15:0]))
		else $error("bytes 5-6 not phase 1 low");

	a_pair56_ph2: assert property ( // RQ8
		proc_tick && state_reg.sel56 == SEL56_PH2_HI |=>
		process_data_object[47:32] == $past(phase_tx_value2[31:16]))
		else $error("bytes 5-6 not phase 2 high");

	a_pair78_analog: assert property ( // RQ9
		proc_tick && state_reg.sel78 == SEL78_ANALOG |=>
		process_data_object[63:48] == $past(analog_tx_word3))
		else $error("bytes 7-8 not analog word 3");

	a_pair78_digital: assert property ( // RQ10
		proc_tick && state_reg.sel78 == SEL78_DIG_HI |=>
		process_data_object[63:48] ==
		$past(free_digital_output_set[31:16]))
		else $error("bytes 7-8 not digital high");

	a_pair78_ph1: assert property ( // RQ11
		proc_tick && state_reg.sel78 == SEL78_PH1_HI |=>
		process_data_object[63:48] == $past(phase_tx_value1[31:16]))
		else $error("bytes 7-8 not phase 1 high");

	a_analog_unscaled: assert property ( // RQ12
		proc_tick && state_reg.sel34 == SEL34_ANALOG
		&& analog_tx_word1 == ANALOG_FULL_SCALE |=>
		process_data_object[31:16] == ANALOG_FULL_SCALE)
		else $error("full-scale analog word altered");

	a_rx_analog1: assert property ( // RQ13
		rx_object_valid |=> rx_fields_valid
		&& analog_rx_word1 == $past(rx_object[31:16]))
		else $error("receive analog word 1 wrong");

	a_rx_upper: assert property ( // RQ14
		rx_object_valid |=> rx_digital_bits == $past(rx_object[63:32])
		&& rx_phase_value == $past(rx_object[63:32])
		&& analog_rx_word2 == $past(rx_object[47:32])
		&& analog_rx_word3 == $past(rx_object[63:48]))
		else $error("receive bytes 5-8 split wrong");

	a_rx_control: assert property ( // RQ15
		rx_object_valid |=> device_control_bits ==
		{$past(rx_object[11:8]), $past(rx_object[3])}
		&& control_free_bits[2:0] == $past(rx_object[2:0]))
		else $error("control word bits misrouted");

	a_reserved_zero: assert property ( // RQ16
		proc_tick && (state_reg.sel34 == 2'h1 || state_reg.sel34 == 2'h2)
		|=> process_data_object[31:16] == 16'h0000)
		else $error("reserved selector on bytes 3-4 not zero");

	a_reserved78_zero: assert property ( // RQ16
		proc_tick && state_reg.sel78 == 2'h3 |=>
		process_data_object[63:48] == 16'h0000)
		else $error("reserved selector on bytes 7-8 not zero");

	a_object_held: assert property ( // RQ17
		!proc_tick |=> $stable(process_data_object))
		else $error("object changed between cycles");

	a_read_answer: assert property (
		reg_rd && reg_addr == ADDR_SEL56 |=>
		reg_rdata == {14'h0000, $past(state_reg.sel56)})
		else $error("selector readback wrong");

	a_read_idle: assert property (
		!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data outside the answer cycle");

	a_valid_on_tick: assert property ( // RQ17
		!proc_tick |=> !process_data_object_valid)
		else $error("object valid without a tick");

	a_tick_period: assert property ( // RQ17
		proc_tick |-> ##TICK_GAP proc_tick)
		else $error("processing cycle period wrong");

	// main scenarios
	c_phase_split: cover property (proc_tick
		&& state_reg.sel56 == SEL56_PH1_LO
		&& state_reg.sel78 == SEL78_PH1_HI);
	c_digital_mix: cover property (proc_tick
		&& state_reg.sel56 == SEL56_PH1_LO
		&& state_reg.sel78 == SEL78_DIG_HI);
	c_reserved: cover property (proc_tick && state_reg.sel34 == 2'h1);
	c_receive: cover property (rx_object_valid ##1 rx_fields_valid);
	c_all_analog: cover property (proc_tick
		&& state_reg.sel34 == SEL34_ANALOG
		&& state_reg.sel56 == SEL56_ANALOG
		&& state_reg.sel78 == SEL78_ANALOG);
endmodule : fieldbus_process_data_mapper
`default_nettype wire

// ==== fieldbus_map_pkg.sv ====
`default_nettype none
package fieldbus_map_pkg;
	// clock and processing cycle
	localparam int CLK_PERIOD_NS = 4;
	localparam int PROC_CYCLE_NS = 1000;
	localparam int PROC_CYCLE_TICKS = PROC_CYCLE_NS / CLK_PERIOD_NS;
	localparam int TICK_CNT_W = 8;
	// object layout: byte n sits at bits 8n-1 downto 8n-8
	localparam int OBJ_W = 64;
	localparam int PAIR12_LSB = 0;
	localparam int PAIR34_LSB = 16;
	localparam int PAIR56_LSB = 32;
	localparam int PAIR78_LSB = 48;
	// scaling of transmitted values
	localparam logic [15:0] ANALOG_FULL_SCALE = 16'h4000;
	localparam logic [31:0] PHASE_PER_REV = 32'h0001_0000;
	// control word bits that go to device control
	localparam int CTRL_BIT_SINGLE = 3;
	localparam int CTRL_FIELD_LSB = 8;
	localparam int CTRL_FIELD_MSB = 11;
	// register map
	localparam int REG_ADDR_W = 4;
	localparam int REG_DATA_W = 16;
	localparam logic [3:0] ADDR_SEL34 = 4'h0;
	localparam logic [3:0] ADDR_SEL56 = 4'h1;
	localparam logic [3:0] ADDR_SEL78 = 4'h2;
	localparam logic [3:0] ADDR_STAT_MASK = 4'h3;
	localparam logic [3:0] ADDR_STAT_VALUE = 4'h4;
	localparam logic [3:0] ADDR_TX_PAIR12 = 4'h8;
	localparam logic [3:0] ADDR_TX_PAIR34 = 4'h9;
	localparam logic [3:0] ADDR_TX_PAIR56 = 4'hA;
	localparam logic [3:0] ADDR_TX_PAIR78 = 4'hB;
	localparam logic [3:0] ADDR_RX_CTRL = 4'hC;
	localparam logic [3:0] ADDR_CYCLES = 4'hD;
	// reset values
	localparam logic [1:0] SEL_RESET = 2'h0;
	localparam logic [15:0] STAT_MASK_RESET = 16'h0000;
	localparam logic [15:0] STAT_VALUE_RESET = 16'h0000;
	// selector codes
	localparam logic [1:0] SEL34_ANALOG = 2'h0;
	localparam logic [1:0] SEL34_PH2_LO = 2'h3;
	localparam logic [1:0] SEL56_ANALOG = 2'h0;
	localparam logic [1:0] SEL56_DIG_LO = 2'h1;
	localparam logic [1:0] SEL56_PH1_LO = 2'h2;
	localparam logic [1:0] SEL56_PH2_HI = 2'h3;
	localparam logic [1:0] SEL78_ANALOG = 2'h0;
	localparam logic [1:0] SEL78_DIG_HI = 2'h1;
	localparam logic [1:0] SEL78_PH1_HI = 2'h2;
endpackage : fieldbus_map_pkg
`default_nettype wire

// ==== rx_fields_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface rx_fields_if;
	logic [15:0] control_word;
	logic [15:0] analog1;
	logic [15:0] analog2;
	logic [15:0] analog3;
	logic [31:0] digital;
	logic [31:0] phase;
	logic valid;
	modport splitter (output control_word, analog1, analog2, analog3,
		digital, phase, valid);
	modport mapper (input control_word, analog1, analog2, analog3,
		digital, phase, valid);
endinterface : rx_fields_if
`default_nettype wire

// ==== proc_cycle_divider.sv ====
`timescale 1ns/100ps
`default_nettype none
module proc_cycle_divider
	import fieldbus_map_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// one-cycle pulse per processing cycle
	output logic tick
);
	typedef struct packed
	{
		logic [TICK_CNT_W-1:0] cnt;
		logic tick;
	} div_state_t;

	div_state_t state_reg;
	div_state_t state_next;

	// free-running count, wraps once per processing cycle
	always_comb
	begin
		state_next = state_reg;
		state_next.tick = 1'b0;
		if (state_reg.cnt == TICK_CNT_W'(PROC_CYCLE_TICKS - 1))
		begin
			state_next.cnt = '0;
			state_next.tick = 1'b1;
		end
		else
			state_next.cnt = state_reg.cnt + 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign tick = state_reg.tick;
endmodule : proc_cycle_divider
`default_nettype wire

// ==== rx_object_splitter.sv ====
`timescale 1ns/100ps
`default_nettype none
module rx_object_splitter
	import fieldbus_map_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// incoming object from the module
	input wire logic [OBJ_W-1:0] rx_object,
	input wire logic rx_object_valid,
	// split fields toward the mapper
	rx_fields_if.splitter rx
);
	typedef struct packed
	{
		logic [OBJ_W-1:0] obj;
		logic valid;
	} split_state_t;

	split_state_t state_reg;
	split_state_t state_next;

	// whole object captured at once so fields always belong together
	always_comb
	begin
		state_next = state_reg;
		state_next.valid = rx_object_valid;
		if (rx_object_valid)
			state_next.obj = rx_object;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	// every reading of bytes 5..8 is offered at once
	assign rx.control_word = state_reg.obj[PAIR12_LSB +: 16];
	assign rx.analog1 = state_reg.obj[PAIR34_LSB +: 16]; // RQ13
	assign rx.analog2 = state_reg.obj[PAIR56_LSB +: 16]; // RQ14
	assign rx.analog3 = state_reg.obj[PAIR78_LSB +: 16]; // RQ14
	assign rx.digital = state_reg.obj[PAIR56_LSB +: 32]; // RQ14
	assign rx.phase = state_reg.obj[PAIR56_LSB +: 32]; // RQ14
	assign rx.valid = state_reg.valid;
endmodule : rx_object_splitter
`default_nettype wire

// ==== fieldbus_module_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module fieldbus_module_model
	import fieldbus_map_pkg::*;
(
	// clock
	input wire logic clk,
	// object from the controller
	input wire logic [OBJ_W-1:0] process_data_object,
	input wire logic process_data_object_valid,
	// object toward the controller
	output logic [OBJ_W-1:0] rx_object,
	output logic rx_object_valid
);
	logic [OBJ_W-1:0] obj_seen;

	// quiet lines until the first frame
	initial
	begin
		rx_object = 64'h0;
		rx_object_valid = 1'h0;
		obj_seen = 64'h0;
	end

	// take the object only on the pulse; between pulses it is not ours
	always @(posedge clk)
	begin
		if (process_data_object_valid)
			obj_seen <= process_data_object;
	end

	// two objects back to back; afterwards the lines show the inverse
	// so a stale object can never pass for a fresh one
	task send(input logic [OBJ_W-1:0] o0, input logic [OBJ_W-1:0] o1);
		@(posedge clk);
		rx_object <= o0;
		rx_object_valid <= 1'h1;
		@(posedge clk);
		rx_object <= o1;
		@(posedge clk);
		rx_object_valid <= 1'h0;
		rx_object <= ~o1;
	endtask : send
endmodule : fieldbus_module_model
`default_nettype wire

// ==== fieldbus_process_data_mapper_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module fieldbus_process_data_mapper_tb
	import fieldbus_map_pkg::*;
;
	localparam logic [15:0] MASK = 16'h0F00;
	localparam logic [15:0] VAL = 16'h0A55;
	localparam logic [63:0] RXO = 64'h89AB_CDEF_5A5A_A5C3;
	logic clk, rst, reg_wr, reg_rd;
	logic [REG_ADDR_W-1:0] reg_addr;
	logic [REG_DATA_W-1:0] reg_wdata, reg_rdata;
	logic [15:0] status_word, analog_tx_word1, analog_tx_word2;
	logic [15:0] analog_tx_word3, analog_rx_word1, analog_rx_word2;
	logic [15:0] analog_rx_word3;
	logic [31:0] phase_tx_value1, phase_tx_value2, free_digital_output_set;
	logic [31:0] rx_digital_bits, rx_phase_value;
	logic [OBJ_W-1:0] process_data_object, rx_object, snap;
	logic process_data_object_valid, rx_object_valid, rx_fields_valid;
	logic [4:0] device_control_bits;
	logic [10:0] control_free_bits;
	int fail_count, checks, obj_count;

	// 250 MHz clock
	always #2 clk = ~clk;

	// object pulses since reset, the expected value of the cycle count
	always @(posedge clk)
	begin
		if (rst)
			obj_count <= 0;
		else if (process_data_object_valid === 1'h1)
			obj_count <= obj_count + 1;
	end

	fieldbus_process_data_mapper uut (.clk(clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .status_word(status_word),
		.analog_tx_word1(analog_tx_word1), .analog_tx_word2(analog_tx_word2),
		.analog_tx_word3(analog_tx_word3), .phase_tx_value1(phase_tx_value1),
		.phase_tx_value2(phase_tx_value2),
		.free_digital_output_set(free_digital_output_set),
		.process_data_object(process_data_object),
		.process_data_object_valid(process_data_object_valid),
		.rx_object(rx_object), .rx_object_valid(rx_object_valid),
		.device_control_bits(device_control_bits),
		.control_free_bits(control_free_bits),
		.analog_rx_word1(analog_rx_word1), .analog_rx_word2(analog_rx_word2),
		.analog_rx_word3(analog_rx_word3), .rx_digital_bits(rx_digital_bits),
		.rx_phase_value(rx_phase_value), .rx_fields_valid(rx_fields_valid));

	fieldbus_module_model far (.clk(clk),
		.process_data_object(process_data_object),
		.process_data_object_valid(process_data_object_valid),
		.rx_object(rx_object), .rx_object_valid(rx_object_valid));

	task results;
		if (fail_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results

	task chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one-cycle strobes with a free cycle after, so no strobe is set twice
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask : wr

	task rdchk(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		chk(64'(reg_rdata), 64'(exp));
	endtask : rdchk

	// bounded wait for the next object pulse
	task wait_obj;
		int i;
		for (i = 0; i < 400; i++)
		begin
			@(posedge clk);
			#1;
			if (process_data_object_valid === 1'h1)
				break;
		end
		if (i == 400)
		begin
			fail_count++;
			$display("Error at %0t: no object update", $time);
			results();
		end
	endtask : wait_obj

	// sources; n flips them so a stale sample shows up
	task set_src(input logic [15:0] n);
		status_word <= 16'h1234 ^ n;
		analog_tx_word1 <= ANALOG_FULL_SCALE ^ n;
		analog_tx_word2 <= 16'hC000 ^ n;
		analog_tx_word3 <= 16'h5A5A ^ n;
		phase_tx_value1 <= (3 * PHASE_PER_REV + 32'h8ACE) ^ {n, n};
		phase_tx_value2 <= 32'h7654_3210 ^ {n, n};
		free_digital_output_set <= 32'hDEAD_BEEF ^ {n, n};
	endtask : set_src

	// expected object from the selector codes and current sources
	function automatic logic [63:0] exp_obj(input logic [1:0] s);
		logic [15:0] p34, p56, p78;
		p34 = (s == 2'h0) ? analog_tx_word1 :
			(s == 2'h3) ? phase_tx_value2[15:0] : 16'h0000;
		p56 = (s == 2'h0) ? analog_tx_word2 :
			(s == 2'h1) ? free_digital_output_set[15:0] :
			(s == 2'h2) ? phase_tx_value1[15:0] : phase_tx_value2[31:16];
		p78 = (s == 2'h0) ? analog_tx_word3 :
			(s == 2'h1) ? free_digital_output_set[31:16] :
			(s == 2'h2) ? phase_tx_value1[31:16] : 16'h0000;
		return {p78, p56, p34, (status_word & ~MASK) | (VAL & MASK)};
	endfunction : exp_obj

	// main sequence
	initial
	begin
		clk = 1'h0;
		rst = 1'h1;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		fail_count = 0;
		checks = 0;
		set_src(16'h0000);
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		for (int a = 0; a < 5; a++)
			rdchk(a[3:0], 16'h0000);
		wr(4'hE, 16'hFFFF);
		rdchk(4'hE, 16'h0000);
		wr(ADDR_STAT_MASK, MASK);
		wr(ADDR_STAT_VALUE, VAL);
		rdchk(ADDR_STAT_MASK, MASK);
		rdchk(ADDR_STAT_VALUE, VAL);
		// every selector code on all three pairs at once
		for (int k = 0; k < 4; k++)
		begin
			wait_obj();
			wr(ADDR_SEL34, {14'h0, k[1:0]});
			wr(ADDR_SEL56, {14'h0, k[1:0]});
			wr(ADDR_SEL78, {14'h0, k[1:0]});
			wait_obj();
			snap = exp_obj(k[1:0]);
			chk(64'(process_data_object[31:16]), 64'(snap[31:16]));
			chk(64'(process_data_object[47:32]), 64'(snap[47:32]));
			chk(64'(process_data_object[63:48]), 64'(snap[63:48]));
			chk(64'(process_data_object[15:0]), 64'(snap[15:0]));
			rdchk(ADDR_SEL56, {14'h0, k[1:0]});
		end
		// sources move mid-cycle: object must hold, then change whole
		wait_obj();
		snap = exp_obj(2'h3);
		@(posedge clk);
		set_src(16'h00FF);
		repeat (20) @(posedge clk);
		#1;
		chk(process_data_object, snap);
		chk(far.obj_seen, snap);
		wait_obj();
		snap = exp_obj(2'h3);
		chk(process_data_object, snap);
		wr(ADDR_TX_PAIR12, 16'hFFFF);
		for (int p = 0; p < 4; p++)
			rdchk(ADDR_TX_PAIR12 | p[3:0], snap[16*p +: 16]);
		rdchk(ADDR_CYCLES, obj_count[15:0]);
		// receive side, two objects back to back
		far.send(64'h1111_2222_3333_4444, RXO);
		#1;
		chk(64'(rx_fields_valid), 64'h1);
		chk(64'(device_control_bits), 64'({RXO[11:8], RXO[3]}));
		chk(64'(control_free_bits), 64'({RXO[15:12], RXO[7:4], RXO[2:0]}));
		chk(64'(analog_rx_word1), 64'(RXO[31:16]));
		chk(64'({analog_rx_word3, analog_rx_word2}), 64'(RXO[63:32]));
		chk(64'(rx_digital_bits), 64'(RXO[63:32]));
		chk(64'(rx_phase_value), 64'(RXO[63:32]));
		@(posedge clk);
		#1;
		chk(64'(rx_fields_valid), 64'h0);
		rdchk(ADDR_RX_CTRL, RXO[15:0]);
		// reset in mid-run: settings, object and fields fall back to zero
		@(posedge clk);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		#1;
		chk(process_data_object, 64'h0);
		chk(64'(analog_rx_word1), 64'h0);
		rdchk(ADDR_SEL56, 16'h0000);
		rdchk(ADDR_STAT_MASK, 16'h0000);
		results();
	end
endmodule : fieldbus_process_data_mapper_tb
`default_nettype wire
